/* verilog/eeprom_map.svh */
// Purpose: Named offsets, field widths, opcodes and timing figures of the serial EEPROM block.
// Assumes: Included by the package and the design modules by its bare name.
// Notes: Array size is the 4K density; x8 uses nine address bits, x16 uses eight.
`ifndef EEPROM_MAP_SVH
`define EEPROM_MAP_SVH

// ----------------------------------------------------------------------------
// Instruction fields
// ----------------------------------------------------------------------------
`define OP_BITS 2
`define OP_READ 2'h2
`define OP_WRITE 2'h1
`define OP_ERASE 2'h3
`define OP_CTRL 2'h0
`define CTRL_ENABLE 2'h3
`define CTRL_ERASE_ALL 2'h2
`define CTRL_WRITE_ALL 2'h1
`define CTRL_DISABLE 2'h0

// ----------------------------------------------------------------------------
// Array geometry
// ----------------------------------------------------------------------------
`define ADDR_W 9
`define ADDR_X8_BITS 9
`define ADDR_X16_BITS 8
`define DATA_W 16
`define DATA_X8_BITS 8
`define DATA_X16_BITS 16
`define ARRAY_BYTES 512
`define ERASED_BYTE 8'hFF
`define CMD_W 28
`define BUF_DEPTH 2
`define CNT_W 5

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define MCLK_PERIOD_NS 100
`define PROG_TIME_NS 10000000
`define CS_LOW_NS 250
`define CS_LOW_CYCLES 2'h3
`define TIMER_W 17

`endif

/* verilog/eeprom_pkg.sv */
// Purpose: Types shared by the serial EEPROM block.
// Assumes: The map header supplies every field width of the command word.
// Notes: State encodings are one-hot.
`include "eeprom_map.svh"

package eeprom_pkg;

	// ------------------------------------------------------------------------
	// State machines and operation kinds
	// ------------------------------------------------------------------------
	typedef enum logic [5:0] {
		L_IDLE = 6'h01,
		L_OP = 6'h02,
		L_ADDR = 6'h04,
		L_DATA = 6'h08,
		L_READ = 6'h10,
		L_DONE = 6'h20
	} link_state_e;

	typedef enum logic [1:0] {
		E_IDLE = 2'h1,
		E_PROG = 2'h2
	} exec_state_e;

	typedef enum logic [3:0] {
		K_ERASE = 4'h1,
		K_WRITE = 4'h2,
		K_ERASE_ALL = 4'h4,
		K_WRITE_ALL = 4'h8
	} prog_kind_e;

	// A fully received instruction as it crosses into the system clock.
	typedef struct packed {
		logic [`OP_BITS-1:0] op;
		logic [`ADDR_W-1:0] addr;
		logic [`DATA_W-1:0] data;
		logic wide;
	} cmd_word_s;

endpackage : eeprom_pkg

/* verilog/eeprom_cmd_buffer.sv */
// Purpose: Two-entry buffer with valid and ready on both sides.
// Assumes: Both sides run on the system clock.
// Notes: Output data comes straight from the storage flip-flops.
`timescale 1ns/1ps
`include "eeprom_map.svh"

module eeprom_cmd_buffer #(
	parameter int WIDTH = `CMD_W,
	parameter int DEPTH = `BUF_DEPTH
) (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [WIDTH-1:0] i_in_data,
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [WIDTH-1:0] o_out_data
);

	localparam int PW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0] wr;
		logic [PW-1:0] rd;
		logic [PW:0] count;
	} buf_s;

	buf_s b;
	buf_s next_b;
	logic push;
	logic pop;

	// Full and empty follow the occupancy count.
	assign o_in_ready = b.count != (PW+1)'(DEPTH);
	assign o_out_valid = b.count != '0;
	assign o_out_data = b.mem[b.rd];
	assign push = i_in_valid & o_in_ready;
	assign pop = o_out_valid & i_out_ready;

	// Pointers wrap at the depth; count moves only on a lone push or pop.
	always_comb begin
		next_b = b;
		if (push) begin
			next_b.mem[b.wr] = i_in_data;
			next_b.wr = (b.wr == PW'(DEPTH-1)) ? '0 : b.wr + PW'(1);
		end
		if (pop) begin
			next_b.rd = (b.rd == PW'(DEPTH-1)) ? '0 : b.rd + PW'(1);
		end
		if (push && !pop) begin
			next_b.count = b.count + (PW+1)'(1);
		end else if (pop && !push) begin
			next_b.count = b.count - (PW+1)'(1);
		end
	end

	// Registers the buffer state; contents need no reset.
	always_ff @(posedge i_mclk) begin
		b <= next_b;
		if (i_rst) begin
			b.wr <= '0;
			b.rd <= '0;
			b.count <= '0;
		end
	end

endmodule : eeprom_cmd_buffer

/* verilog/eeprom_prog_ctrl.sv */
// Purpose: Serial EEPROM device: instruction capture, programming latch, self-timed cycle, status.
// Assumes: Select and serial input are launched by the host relative to the shift clock.
// Notes: Link capture runs on the shift clock; the array and timer run on i_mclk.
//
// Operation
// - After reset programming is disabled; erase and write are refused.
// - Enable persists across instructions until disable or reset.
// - Erase sets the addressed word to ones; cycle starts after address.
// - Write carries an 8 or 16 bit word; cycle starts after its last bit.
// - Host holds select low 250 ns then raises it; status then appears.
// - Status reads zero while busy and one when ready again.
// - No status if select first rises after the cycle has finished.
// - Erase-all sets the whole array to ones, with status like erase.
// - Write-all stores the one data word everywhere, with status.
// - Disable blocks all programming; host issues it when finished.
// - Reads work whether programming is enabled or disabled.
// - Address field width follows density and word organization.
// - An instruction begins after select rises with a start bit of one.
// - Opcodes: 10 read, 01 write, 11 erase, 00 with address-top subcodes.
// - A read sends a zero bit before the data word.
// - Organization input high selects 16-bit words, low selects 8-bit.
`timescale 1ns/1ps
`include "eeprom_map.svh"

module eeprom_prog_ctrl #(
	parameter int PROG_CYCLES = `PROG_TIME_NS / `MCLK_PERIOD_NS
) (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_shift_clock_in,
	input wire logic i_select,
	input wire logic i_serial_in,
	input wire logic i_word_width_select,
	output logic o_serial_out,
	output logic o_serial_out_oe
);

	// ------------------------------------------------------------------------
	// State of both domains
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic rst_meta;
		logic rst_sync;
		logic org_meta;
		logic word_width_select;
		eeprom_pkg::link_state_e state;
		logic [`CNT_W-1:0] cnt;
		logic [`OP_BITS-1:0] op;
		logic [`ADDR_W-1:0] addr;
		logic [`DATA_W-1:0] data;
		logic wide;
		logic [`DATA_W-1:0] shout;
		logic dout;
		logic dout_oe;
		logic toggle;
		eeprom_pkg::cmd_word_s cmd;
	} link_s;

	typedef struct packed {
		logic cs_meta;
		logic cs_sync;
		logic cs_prev;
		logic tog_meta;
		logic tog_sync;
		logic tog_prev;
		logic pending;
		logic pe;
		eeprom_pkg::exec_state_e state;
		eeprom_pkg::prog_kind_e kind;
		logic [`ADDR_W-1:0] addr;
		logic [`DATA_W-1:0] data;
		logic wide;
		logic [`TIMER_W-1:0] timer;
		logic [1:0] cs_low;
		logic armed;
		logic status_on;
		logic ready_do;
		logic [`ARRAY_BYTES-1:0][7:0] mem;
	} exec_s;

	link_s l;
	link_s next_l;
	exec_s e;
	exec_s next_e;

	logic buf_in_ready;
	logic buf_out_valid;
	logic [`CMD_W-1:0] buf_out_raw;
	eeprom_pkg::cmd_word_s buf_word;
	logic prog_done;
	logic busy;
	logic new_word;
	logic [`ARRAY_BYTES-1:0][7:0] mem_next;

	// Top two address bits carry the subcode of the control opcode.
	function automatic logic [1:0] ctrl_code(input logic [`ADDR_W-1:0] a, input logic w);
		ctrl_code = w ? a[`ADDR_X16_BITS-1 -: 2] : a[`ADDR_X8_BITS-1 -: 2];
	endfunction : ctrl_code

	// True for every instruction that starts a self-timed cycle.
	function automatic logic is_prog(input eeprom_pkg::cmd_word_s c);
		is_prog = (c.op == `OP_WRITE) || (c.op == `OP_ERASE) ||
			((c.op == `OP_CTRL) && ((ctrl_code(c.addr, c.wide) == `CTRL_ERASE_ALL) ||
			(ctrl_code(c.addr, c.wide) == `CTRL_WRITE_ALL)));
	endfunction : is_prog

	// ------------------------------------------------------------------------
	// Link side, on the shift clock
	// ------------------------------------------------------------------------

	// Shifts instruction bits in on rising edges and read data out on rising edges.
	// The array is read across domains without a handshake: it only changes at the
	// end of a self-timed cycle, and reads during a cycle are not meaningful anyway.
	always_comb begin
		logic [`ADDR_W-1:0] full_addr;
		logic [`DATA_W-1:0] full_data;
		logic [`ADDR_W-1:0] idx16;
		full_addr = {l.addr[`ADDR_W-2:0], i_serial_in};
		full_data = {l.data[`DATA_W-2:0], i_serial_in};
		idx16 = {full_addr[`ADDR_X16_BITS-1:0], 1'b0};
		next_l = l;
		next_l.rst_meta = i_rst;
		next_l.rst_sync = l.rst_meta;
		next_l.org_meta = i_word_width_select;
		next_l.word_width_select = l.org_meta;
		if (l.rst_sync) begin
			next_l.state = eeprom_pkg::L_IDLE;
			next_l.dout = 1'b0;
			next_l.dout_oe = 1'b0;
			next_l.toggle = 1'b0;
		end else if (!i_select) begin
			// Select low ends any frame, so the next one starts clean.
			next_l.state = eeprom_pkg::L_IDLE;
			next_l.dout_oe = 1'b0;
		end else begin
			case (l.state)
				eeprom_pkg::L_IDLE: begin
					if (i_serial_in) begin
						next_l.state = eeprom_pkg::L_OP;
						next_l.cnt = '0;
					end
				end
				eeprom_pkg::L_OP: begin
					next_l.op = {l.op[0], i_serial_in};
					if (l.cnt == `CNT_W'(`OP_BITS-1)) begin
						next_l.state = eeprom_pkg::L_ADDR;
						next_l.cnt = '0;
						next_l.wide = l.word_width_select;
					end else begin
						next_l.cnt = l.cnt + `CNT_W'(1);
					end
				end
				eeprom_pkg::L_ADDR: begin
					next_l.addr = full_addr;
					if (l.cnt == (l.wide ? `CNT_W'(`ADDR_X16_BITS-1) :
						`CNT_W'(`ADDR_X8_BITS-1))) begin
						next_l.cnt = '0;
						if (l.op == `OP_READ) begin
							// Read needs no enable; dummy zero goes out first.
							next_l.state = eeprom_pkg::L_READ;
							next_l.dout = 1'b0;
							next_l.dout_oe = 1'b1;
							next_l.shout = l.wide ? {e.mem[idx16 + `ADDR_W'(1)], e.mem[idx16]} :
								{e.mem[full_addr], 8'h00};
						end else if ((l.op == `OP_WRITE) || ((l.op == `OP_CTRL) &&
							(ctrl_code(full_addr, l.wide) == `CTRL_WRITE_ALL))) begin
							next_l.state = eeprom_pkg::L_DATA;
						end else begin
							// Erase and control words other than write-all are complete once decoded.
							next_l.state = eeprom_pkg::L_DONE;
							next_l.cmd = '{op: l.op, addr: full_addr, data: l.data, wide: l.wide};
							next_l.toggle = ~l.toggle;
						end
					end else begin
						next_l.cnt = l.cnt + `CNT_W'(1);
					end
				end
				eeprom_pkg::L_DATA: begin
					next_l.data = full_data;
					if (l.cnt == (l.wide ? `CNT_W'(`DATA_X16_BITS-1) :
						`CNT_W'(`DATA_X8_BITS-1))) begin
						// Last data bit received: hand the word over.
						next_l.state = eeprom_pkg::L_DONE;
						next_l.cmd = '{op: l.op, addr: l.addr, data: full_data, wide: l.wide};
						next_l.toggle = ~l.toggle;
					end else begin
						next_l.cnt = l.cnt + `CNT_W'(1);
					end
				end
				eeprom_pkg::L_READ: begin
					next_l.dout = l.shout[`DATA_W-1];
					next_l.shout = {l.shout[`DATA_W-2:0], 1'b0};
				end
				eeprom_pkg::L_DONE: begin
					next_l.dout_oe = 1'b0;
				end
				default: begin
					next_l.state = eeprom_pkg::L_IDLE;
				end
			endcase
		end
	end

	// Registers the link state on the host's shift clock.
	always_ff @(posedge i_shift_clock_in) begin
		l <= next_l;
	end

	// ------------------------------------------------------------------------
	// Command buffer between the crossing and the executor
	// ------------------------------------------------------------------------
	eeprom_cmd_buffer #(
		.WIDTH(`CMD_W),
		.DEPTH(`BUF_DEPTH)
	) u_buffer (
		.i_mclk(i_mclk),
		.i_rst(i_rst),
		.i_in_valid(e.pending),
		.o_in_ready(buf_in_ready),
		.i_in_data(l.cmd),
		.o_out_valid(buf_out_valid),
		.i_out_ready(e.state == eeprom_pkg::E_IDLE),
		.o_out_data(buf_out_raw)
	);

	assign buf_word = eeprom_pkg::cmd_word_s'(buf_out_raw);

	// ------------------------------------------------------------------------
	// Array update, one slice per byte
	// ------------------------------------------------------------------------
	assign prog_done = (e.state == eeprom_pkg::E_PROG) && (e.timer == '0);

	for (genvar gi = 0; gi < `ARRAY_BYTES; gi++) begin : g_byte
		localparam logic [`ADDR_W-1:0] IDX = `ADDR_W'(gi);
		logic all_hit;
		logic one_hit;
		logic erase;
		assign all_hit = (e.kind == eeprom_pkg::K_ERASE_ALL) ||
			(e.kind == eeprom_pkg::K_WRITE_ALL);
		assign one_hit = e.wide ? (IDX[`ADDR_W-1:1] == e.addr[`ADDR_X16_BITS-1:0]) :
			(IDX == e.addr);
		assign erase = (e.kind == eeprom_pkg::K_ERASE) || (e.kind == eeprom_pkg::K_ERASE_ALL);
		// Erase writes ones; x16 puts the high byte at the odd index.
		assign mem_next[gi] = !(prog_done && (all_hit || one_hit)) ? e.mem[gi] :
			erase ? `ERASED_BYTE :
			(e.wide && IDX[0]) ? e.data[15:8] : e.data[7:0];
	end

	// ------------------------------------------------------------------------
	// Executor, on the system clock
	// ------------------------------------------------------------------------
	assign new_word = e.tog_sync != e.tog_prev;
	assign busy = (e.state == eeprom_pkg::E_PROG) || e.pending || buf_out_valid;

	// Decodes buffered words, times the cycle and drives ready/busy status.
	always_comb begin
		logic cs_rise;
		cs_rise = e.cs_sync && !e.cs_prev;
		next_e = e;
		next_e.cs_meta = i_select;
		next_e.cs_sync = e.cs_meta;
		next_e.cs_prev = e.cs_sync;
		next_e.tog_meta = l.toggle;
		next_e.tog_sync = e.tog_meta;
		next_e.tog_prev = e.tog_sync;
		next_e.mem = mem_next;
		next_e.ready_do = !busy;
		// A toggle edge means a stable word waits in the link register.
		if (new_word) begin
			next_e.pending = 1'b1;
		end else if (e.pending && buf_in_ready) begin
			next_e.pending = 1'b0;
		end
		// Measures how long select stayed low before it rises.
		if (e.cs_sync) begin
			next_e.cs_low = '0;
		end else if (e.cs_low != `CS_LOW_CYCLES) begin
			next_e.cs_low = e.cs_low + 2'h1;
		end
		case (e.state)
			eeprom_pkg::E_IDLE: begin
				if (buf_out_valid) begin
					next_e.addr = buf_word.addr;
					next_e.data = buf_word.data;
					next_e.wide = buf_word.wide;
					next_e.timer = `TIMER_W'(PROG_CYCLES - 1);
					if (buf_word.op == `OP_CTRL) begin
						case (ctrl_code(buf_word.addr, buf_word.wide))
							`CTRL_ENABLE: begin
								next_e.pe = 1'b1;
							end
							`CTRL_DISABLE: begin
								next_e.pe = 1'b0;
							end
							`CTRL_ERASE_ALL: begin
								next_e.kind = eeprom_pkg::K_ERASE_ALL;
								next_e.state = e.pe ? eeprom_pkg::E_PROG : eeprom_pkg::E_IDLE;
							end
							default: begin
								next_e.kind = eeprom_pkg::K_WRITE_ALL;
								next_e.state = e.pe ? eeprom_pkg::E_PROG : eeprom_pkg::E_IDLE;
							end
						endcase
					end else if (buf_word.op == `OP_ERASE) begin
						next_e.kind = eeprom_pkg::K_ERASE;
						next_e.state = e.pe ? eeprom_pkg::E_PROG : eeprom_pkg::E_IDLE;
					end else if (buf_word.op == `OP_WRITE) begin
						next_e.kind = eeprom_pkg::K_WRITE;
						next_e.state = e.pe ? eeprom_pkg::E_PROG : eeprom_pkg::E_IDLE;
					end
				end
			end
			eeprom_pkg::E_PROG: begin
				if (prog_done) begin
					next_e.state = eeprom_pkg::E_IDLE;
				end else begin
					next_e.timer = e.timer - `TIMER_W'(1);
				end
			end
			default: begin
				next_e.state = eeprom_pkg::E_IDLE;
			end
		endcase
		// Status is owed only if select rises while the cycle still runs.
		if (new_word && e.pe && is_prog(l.cmd)) begin
			next_e.armed = 1'b1;
		end else if (cs_rise) begin
			next_e.armed = 1'b0;
			next_e.status_on = e.armed && busy && (e.cs_low == `CS_LOW_CYCLES);
		end else if (!busy) begin
			next_e.armed = 1'b0;
		end
		if (!e.cs_sync) begin
			next_e.status_on = 1'b0;
		end
	end

	// Registers executor state; the array keeps its contents through reset.
	always_ff @(posedge i_mclk) begin
		e <= next_e;
		if (i_rst) begin
			e.pending <= 1'b0;
			e.pe <= 1'b0;
			e.state <= eeprom_pkg::E_IDLE;
			e.kind <= eeprom_pkg::K_ERASE;
			e.timer <= '0;
			e.cs_low <= '0;
			e.armed <= 1'b0;
			e.status_on <= 1'b0;
			e.ready_do <= 1'b1;
		end
	end

	// Serial output carries status after a programming instruction, else read data.
	assign o_serial_out = e.status_on ? e.ready_do : l.dout;
	assign o_serial_out_oe = e.status_on | l.dout_oe;

endmodule : eeprom_prog_ctrl

/* verification/eeprom_prog_ctrl_chk.sv */
// Purpose: Port checks of the serial EEPROM programming control.
// Assumes: The host keeps the shift clock low outside frames.
// Notes: A quiet count tells status polling apart from running frames.
`timescale 1ns/1ps

module eeprom_prog_ctrl_chk #(
	parameter int PROG_CYCLES = 50
) (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_shift_clock_in,
	input wire logic i_select,
	input wire logic i_serial_in,
	input wire logic i_word_width_select,
	input wire logic o_serial_out,
	input wire logic o_serial_out_oe
);
	localparam int BUSY_MAX = PROG_CYCLES + 4;
	logic [2:0] quiet_cnt;
	logic quiet;

	// Counts system clocks with the shift clock at rest; a running link never reaches four.
	always_ff @(posedge i_mclk) begin
		if (i_rst || i_shift_clock_in) begin
			quiet_cnt <= 3'h0;
		end else if (quiet_cnt != 3'h7) begin
			quiet_cnt <= quiet_cnt + 3'h1;
		end
	end
	assign quiet = (quiet_cnt >= 3'h4);

	chk_oe_release: assert property (@(posedge i_mclk) disable iff (i_rst)
		!i_select [*6] |-> !o_serial_out_oe)
		else $error("serial out driven long after select low");
	chk_oe_needs_sel: assert property (@(posedge i_mclk) disable iff (i_rst)
		$rose(o_serial_out_oe) |-> i_select)
		else $error("serial out driven without select");
	chk_status_busy: assert property (@(posedge i_mclk) disable iff (i_rst)
		$rose(o_serial_out_oe) && quiet |-> !o_serial_out)
		else $error("status shown while not busy");
	chk_busy_bounded: assert property (@(posedge i_mclk) disable iff (i_rst)
		$rose(o_serial_out_oe) && quiet && !o_serial_out
		|-> ##[1:BUSY_MAX] (o_serial_out || !i_select))
		else $error("busy status outlasts the cycle");
	chk_ready_holds: assert property (@(posedge i_mclk) disable iff (i_rst)
		o_serial_out_oe && o_serial_out && i_select && quiet |=> o_serial_out)
		else $error("ready status fell back to busy");
	chk_status_stands: assert property (@(posedge i_mclk) disable iff (i_rst)
		o_serial_out_oe && i_select && quiet |=> o_serial_out_oe)
		else $error("status dropped while select high");
	chk_read_dummy: assert property (@(posedge i_shift_clock_in) disable iff (i_rst)
		$rose(o_serial_out_oe) |-> !o_serial_out)
		else $error("read data not led by a zero");
	chk_frame_end_off: assert property (@(posedge i_shift_clock_in) disable iff (i_rst)
		!i_select |=> !o_serial_out_oe)
		else $error("serial out driven after frame end");
endmodule : eeprom_prog_ctrl_chk

bind eeprom_prog_ctrl eeprom_prog_ctrl_chk #(.PROG_CYCLES(PROG_CYCLES)) eeprom_prog_ctrl_chk_i (
	.i_mclk(i_mclk),
	.i_rst(i_rst),
	.i_shift_clock_in(i_shift_clock_in),
	.i_select(i_select),
	.i_serial_in(i_serial_in),
	.i_word_width_select(i_word_width_select),
	.o_serial_out(o_serial_out),
	.o_serial_out_oe(o_serial_out_oe)
);

/* verification/eeprom_host_model.sv */
// Purpose: Host side of the three-wire link: frames, reads and status polls.
// Assumes: Shift clock period 64 ns, still outside frames.
// Notes: A released output line is seen as high impedance.
`timescale 1ns/1ps

module eeprom_host_model (
	input wire logic i_serial_out,
	input wire logic i_serial_out_oe,
	output logic o_shift_clock,
	output logic o_select,
	output logic o_serial_in
);
	// Idle levels at time zero.
	initial begin
		o_shift_clock = 1'b0;
		o_select = 1'b0;
		o_serial_in = 1'b0;
	end

	// Bare shift clock pulses, used around reset and strap changes.
	task automatic pulses(input int n);
		repeat (n) begin
			#32 o_shift_clock = 1'b1;
			#32 o_shift_clock = 1'b0;
		end
	endtask : pulses

	// One frame MSB first; the line is sampled after each falling edge.
	task automatic xfer(input logic [31:0] bits, input int n, output logic [31:0] rx);
		rx = '0;
		o_select = 1'b1;
		for (int k = n - 1; k >= 0; k--) begin
			o_serial_in = bits[k];
			pulses(1);
			rx = {rx[30:0], i_serial_out_oe ? i_serial_out : 1'bz};
		end
		o_select = 1'b0;
		o_serial_in = ~o_serial_in;
		pulses(1);
	endtask : xfer

	// Keeps select low, raises it and follows the ready/busy level.
	task automatic poll(output logic seen, output logic busy, output logic ready);
		#500 o_select = 1'b1;
		#500 seen = i_serial_out_oe;
		busy = i_serial_out_oe ? ~i_serial_out : 1'bz;
		for (int k = 0; k < 100 && i_serial_out_oe === 1'b1 && i_serial_out === 1'b0; k++) begin
			#100;
		end
		ready = i_serial_out_oe ? i_serial_out : 1'bz;
		o_select = 1'b0;
		#600 pulses(1);
	endtask : poll
endmodule : eeprom_host_model

/* verification/tb.sv */
// Purpose: Self-checking bench of the serial EEPROM programming control.
// Assumes: Short self-timed cycle of 50 system clocks.
// Notes: Expected array contents follow from the instructions sent.
`timescale 1ns/1ps
`include "eeprom_map.svh"

module tb;
	logic mclk, rst, wide, sk, sel, di, dout, dout_oe;
	int n_mismatch = 0;
	int tests_run = 0;
	int cycles = 0;

	eeprom_prog_ctrl #(.PROG_CYCLES(50)) eeprom_prog_ctrl_i (
		.i_mclk(mclk),
		.i_rst(rst),
		.i_shift_clock_in(sk),
		.i_select(sel),
		.i_serial_in(di),
		.i_word_width_select(wide),
		.o_serial_out(dout),
		.o_serial_out_oe(dout_oe)
	);
	eeprom_host_model eeprom_host_model_i (
		.i_serial_out(dout),
		.i_serial_out_oe(dout_oe),
		.o_shift_clock(sk),
		.o_select(sel),
		.o_serial_in(di)
	);

	// System clock and hang guard.
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 3000) begin
			n_mismatch++;
			final_report();
		end
	end

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : final_report

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// Builds start bit, opcode, address and dw data bits and sends them.
	task automatic frame(input logic [1:0] op, input logic [8:0] a, input logic [15:0] d,
		input int dw, output logic [31:0] rx);
		int aw;
		logic [31:0] bits;
		aw = wide ? 8 : 9;
		bits = {29'h0, 1'b1, op};
		bits = (bits << aw) | 32'(a);
		bits = (bits << dw) | 32'(d);
		eeprom_host_model_i.xfer(bits, 3 + aw + dw, rx);
	endtask : frame

	// Control instruction; the subcode sits in the top address bits.
	task automatic ctrl(input logic [1:0] sub, input int dw, input logic [15:0] d);
		logic [31:0] rx;
		frame(`OP_CTRL, wide ? {1'b0, sub, 6'h0} : {sub, 7'h0}, d, dw, rx);
	endtask : ctrl

	task automatic wr(input logic [1:0] op, input logic [8:0] a, input logic [15:0] d);
		logic [31:0] rx;
		frame(op, a, d, (op == `OP_ERASE) ? 0 : (wide ? 16 : 8), rx);
	endtask : wr

	task automatic rd(input logic [8:0] a, input logic [15:0] exp);
		logic [31:0] rx;
		int dw;
		dw = wide ? 16 : 8;
		frame(`OP_READ, a, 16'h0, dw, rx);
		chk("dummy bit", 16'h0, {15'h0, rx[dw]});
		chk("read word", exp, wide ? rx[15:0] : {8'h0, rx[7:0]});
	endtask : rd

	task automatic status(input logic exp_seen);
		logic seen, busy, ready;
		eeprom_host_model_i.poll(seen, busy, ready);
		chk("status shown", {15'h0, exp_seen}, {15'h0, seen});
		if (exp_seen) begin
			chk("status busy", 16'h1, {15'h0, busy});
			chk("status ready", 16'h1, {15'h0, ready});
		end
	endtask : status

	task automatic t_locked();
		ctrl(`CTRL_ERASE_ALL, 0, 16'h0);
		status(1'b0);
		$display("test locked done");
	endtask : t_locked

	task automatic t_erase_all();
		ctrl(`CTRL_ENABLE, 0, 16'h0);
		ctrl(`CTRL_ERASE_ALL, 0, 16'h0);
		status(1'b1);
		rd(9'h000, 16'h00FF);
		rd(9'h1FF, 16'h00FF);
		$display("test erase_all done");
	endtask : t_erase_all

	task automatic t_write_erase();
		wr(`OP_WRITE, 9'h1A5, 16'h003C);
		status(1'b1);
		rd(9'h1A5, 16'h003C);
		wr(`OP_ERASE, 9'h1A5, 16'h0);
		status(1'b1);
		rd(9'h1A5, 16'h00FF);
		$display("test write_erase done");
	endtask : t_write_erase

	task automatic t_late_queue();
		wr(`OP_WRITE, 9'h002, 16'h0081);
		#8000 status(1'b0);
		rd(9'h002, 16'h0081);
		wr(`OP_WRITE, 9'h003, 16'h0011);
		wr(`OP_WRITE, 9'h004, 16'h0022);
		#15000 rd(9'h003, 16'h0011);
		rd(9'h004, 16'h0022);
		$display("test late_queue done");
	endtask : t_late_queue

	task automatic t_disable();
		ctrl(`CTRL_DISABLE, 0, 16'h0);
		wr(`OP_WRITE, 9'h005, 16'h0000);
		status(1'b0);
		rd(9'h005, 16'h00FF);
		$display("test disable done");
	endtask : t_disable

	task automatic t_wide();
		@(negedge mclk) wide = 1'b1;
		eeprom_host_model_i.pulses(3);
		ctrl(`CTRL_ENABLE, 0, 16'h0);
		ctrl(`CTRL_WRITE_ALL, 16, 16'hA55A);
		status(1'b1);
		rd(9'h07F, 16'hA55A);
		@(negedge mclk) wide = 1'b0;
		eeprom_host_model_i.pulses(3);
		rd(9'h000, 16'h005A);
		rd(9'h1FF, 16'h00A5);
		ctrl(`CTRL_DISABLE, 0, 16'h0);
		$display("test wide done");
	endtask : t_wide

	// Reset with the shift clock running, then the scenarios in order.
	initial begin
		rst = 1'b1;
		wide = 1'b0;
		fork
			eeprom_host_model_i.pulses(7);
			repeat (4) @(negedge mclk);
		join
		@(negedge mclk) rst = 1'b0;
		eeprom_host_model_i.pulses(4);
		t_locked();
		t_erase_all();
		t_write_erase();
		t_late_queue();
		t_disable();
		t_wide();
		final_report();
	end
endmodule : tb
